// >>> prsc_top.v
// Loop reference select control: operation-mode register, source mux, frame marker
// Assumes frame pulse, serial clock and reference pin are synchronous to clk_i
`timescale 1ns/1ps
`include "prsc_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - Frequency code 00 is 8 kHz, 01 1.544 MHz, 10 2.048 MHz, 11 reserved
// - Select bit low takes dedicated pin, high takes internal 8 kHz
// - Internal 8 kHz made from frame pulse and serial clock, marks frames
// - Missing frame pulse or serial clock blocks serial stream input data
module prsc_top #(
  parameter CK_W = 8,
  parameter FP_W = 20,
  parameter [FP_W-1:0] FP_TIMEOUT = `PRSC_FP_TIMEOUT
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  input wire ref_pin_i,
  input wire frame_pulse_in_i,
  input wire serial_clock_in_i,
  input wire [15:0] serial_stream_inputs_i,
  output reg loop_ref_o,
  output reg [1:0] ref_freq_code_o,
  output reg free_run_o,
  output reg master_track_o,
  output reg stream_accept_o,
  output reg [15:0] stream_data_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] pll_operation_mode_reg;
  reg [15:0] ctrl_reg;
  reg lost_seen;
  reg [15:0] next_mode;
  reg [15:0] next_ctrl;
  reg next_lost;
  reg [31:0] next_rdata;
  reg next_loop_ref;
  reg [1:0] next_freq_code;
  reg next_free_run;
  reg [15:0] next_stream;
  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [15:0] mode_mask;
  wire ck_alive;
  wire fp_alive;
  wire fp_edge;
  wire req;
  wire wr_req;
  wire rd_req;
  wire hit_mode;
  wire hit_stat;
  wire hit_ctrl;
  wire mapped;
  wire sel_int;
  wire [1:0] freq;
  wire bad_freq;
  wire pin_ref;
  wire int_ref;
  wire free_req;
  wire inputs_ok;
  wire lost_now;
  wire lost_clear;
  wire [5:0] status;
  assign mode_mask = `PRSC_OPMODE_MASK;
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr_req = req & we_i;
  assign rd_req = req & ~we_i;
  assign hit_mode = adr_i == `PRSC_OFS_OPMODE;
  assign hit_stat = adr_i == `PRSC_OFS_STATUS;
  assign hit_ctrl = adr_i == `PRSC_OFS_CTRL;
  assign mapped = hit_mode | hit_stat | hit_ctrl;
  assign sel_int = pll_operation_mode_reg[`PRSC_BIT_SEL];
  assign freq = pll_operation_mode_reg[`PRSC_FREQ_MSB:`PRSC_FREQ_LSB];
  assign bad_freq = (freq == `PRSC_FREQ_RSVD) | (sel_int & (freq != `PRSC_FREQ_8K));
  assign pin_ref = ref_pin_i ^ pll_operation_mode_reg[`PRSC_BIT_INV];
  assign int_ref = fp_edge & ck_alive;
  assign free_req = pll_operation_mode_reg[`PRSC_BIT_FREE] & ~ctrl_reg[`PRSC_CTRL_HOLD_BIT];
  assign inputs_ok = ck_alive & fp_alive;
  assign lost_now = sel_int & ~inputs_ok;
  assign lost_clear = wr_req & hit_stat & sel_i[0] & dat_i[0];
  assign status = {stream_accept_o, loop_ref_o, fp_alive, ck_alive, bad_freq, lost_seen};
  assign err_o = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Activity monitors
  prsc_act_mon #(.W(CK_W)) u_ck_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(serial_clock_in_i),
    .limit_i(`PRSC_CK_TIMEOUT),
    .alive_o(ck_alive),
    .edge_o()
  );
  prsc_act_mon #(.W(FP_W)) u_fp_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(frame_pulse_in_i),
    .limit_i(FP_TIMEOUT),
    .alive_o(fp_alive),
    .edge_o(fp_edge)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Mode register next state
  always @* begin
    next_mode = pll_operation_mode_reg;
    if (wr_req && hit_mode && sel_i[0]) begin
      // Select and frequency bits stored independently
      next_mode[7:0] = dat_i[7:0] & mode_mask[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Control register next state
  always @* begin
    next_ctrl = ctrl_reg;
    if (wr_req && hit_ctrl) begin
      if (sel_i[0]) begin
        next_ctrl[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        next_ctrl[15:8] = dat_i[15:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Lost-source flag, set wins over clear
  always @* begin
    next_lost = lost_seen;
    if (lost_now) begin
      next_lost = 1'b1;
    end else if (lost_clear) begin
      next_lost = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    next_rdata = dat_o;
    if (rd_req) begin
      if (!mapped) begin
        next_rdata = 32'h00000000;
      end else if (hit_mode) begin
        next_rdata = {16'h0000, pll_operation_mode_reg};
      end else if (hit_stat) begin
        next_rdata = {{26{1'b0}}, status};
      end else begin
        next_rdata = {16'h0000, ctrl_reg};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Reference selection
  always @* begin
    if (sel_int) begin
      next_loop_ref = int_ref;
      next_freq_code = `PRSC_FREQ_8K;
    end else begin
      next_loop_ref = pin_ref;
      next_freq_code = freq;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Free run and stream capture
  always @* begin
    next_free_run = free_req;
    next_stream = stream_data_o;
    if (inputs_ok) begin
      next_stream = serial_stream_inputs_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      pll_operation_mode_reg <= `PRSC_OPMODE_RST;
      ctrl_reg <= `PRSC_CTRL_RST;
      lost_seen <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      pll_operation_mode_reg <= next_mode;
      ctrl_reg <= next_ctrl;
      lost_seen <= next_lost;
      ack_o <= req;
      dat_o <= next_rdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Reference outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      loop_ref_o <= 1'b0;
      ref_freq_code_o <= `PRSC_FREQ_8K;
      free_run_o <= 1'b0;
      master_track_o <= 1'b0;
    end else begin
      loop_ref_o <= next_loop_ref;
      ref_freq_code_o <= next_freq_code;
      free_run_o <= next_free_run;
      master_track_o <= ~next_free_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Stream outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      stream_accept_o <= 1'b0;
      stream_data_o <= 16'h0000;
    end else begin
      stream_accept_o <= inputs_ok;
      stream_data_o <= next_stream;
    end
  end
endmodule // prsc_top

// >>> prsc_map.vh
// Register map and field constants for the loop reference select control
// Assumes a 32-bit classic Wishbone slave with word addressing on byte offsets
`ifndef PRSC_MAP_VH
`define PRSC_MAP_VH
`define PRSC_OFS_OPMODE 4'h0
`define PRSC_OFS_STATUS 4'h4
`define PRSC_OFS_CTRL 4'h8
`define PRSC_OPMODE_RST 16'h0000
`define PRSC_OPMODE_MASK 16'h009b
`define PRSC_BIT_FREE 0
`define PRSC_BIT_SEL 1
`define PRSC_FREQ_LSB 3
`define PRSC_FREQ_MSB 4
`define PRSC_BIT_INV 7
`define PRSC_CTRL_HOLD_BIT 14
`define PRSC_CTRL_RST 16'h0000
`define PRSC_FREQ_8K 2'h0
`define PRSC_FREQ_1544K 2'h1
`define PRSC_FREQ_2048K 2'h2
`define PRSC_FREQ_RSVD 2'h3
`define PRSC_CK_TIMEOUT 8'h40
`define PRSC_FP_TIMEOUT 20'h0c350
`endif

// >>> prsc_act_mon.v
// Activity monitor: flags a signal as lost when no edge is seen for a time
// Assumes the watched level is synchronous to clk_i
`timescale 1ns/1ps
module prsc_act_mon #(
  parameter W = 20
) (
  input wire clk_i,
  input wire rst_i,
  input wire sig_i,
  input wire [W-1:0] limit_i,
  output reg alive_o,
  output wire edge_o
);
  reg prev;
  reg [W-1:0] cnt;
  assign edge_o = sig_i & ~prev;
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
      cnt <= {W{1'b0}};
      alive_o <= 1'b0;
    end else begin
      prev <= sig_i;
      if (sig_i != prev) begin
        cnt <= {W{1'b0}};
        alive_o <= 1'b1;
      end else if (cnt >= limit_i) begin
        alive_o <= 1'b0;
      end else begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // prsc_act_mon

// >>> prsc_net_src.sv
// Partner: frame pulse and serial clock source
// Assumes clk_i is the device clock; en_i low is a lost source
`timescale 1ns/1ps
module prsc_net_src #(
  parameter P = 40
) (
  input wire clk_i,
  input wire en_i,
  output reg fp_o,
  output reg ck_o
);
  integer c = 0;
  initial fp_o = 0;
  initial ck_o = 0;
  always @(posedge clk_i) begin
    if (en_i) begin
      c <= (c == P - 1) ? 0 : c + 1;
      ck_o <= ~ck_o;
      fp_o <= (c == 0);
    end
  end
endmodule // prsc_net_src

// >>> prsc_top_checker.sv
// Checker on prsc_top ports
// Assumes bind to every prsc_top
`timescale 1ns/1ps
module prsc_top_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire free_run_o,
  input wire master_track_o,
  input wire stream_accept_o,
  input wire [15:0] serial_stream_inputs_i,
  input wire [15:0] stream_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req; cyc_i && stb_i && !ack_o; endsequence
  chk_ack_answer: assert property (wb_req |=> ack_o) else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
  chk_free_track: assert property (free_run_o |-> !master_track_o) else $error("free");
  chk_track_back: assert property (!free_run_o [*3] |-> master_track_o) else $error("track");
  chk_stream_cap: assert property (stream_accept_o [*2] |->
    stream_data_o == $past(serial_stream_inputs_i)) else $error("cap");
  chk_stream_hold: assert property (!stream_accept_o [*2] |-> $stable(stream_data_o)) else $error("hold");
endmodule // prsc_top_checker
bind prsc_top prsc_top_checker CHK (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .free_run_o(free_run_o), .master_track_o(master_track_o), .stream_accept_o(stream_accept_o),
  .serial_stream_inputs_i(serial_stream_inputs_i), .stream_data_o(stream_data_o));

// >>> prsc_top_tb.sv
// Bench: prsc_top over Wishbone against a model
// Assumes prsc_net_src as frame and clock source
`timescale 1ns/1ps
module prsc_top_tb;
  reg clk_i=0,rst_i=1,cyc_i=0,stb_i=0,we_i=0,ref_pin_i=0,en=0;
  reg [3:0] adr_i=0;
  reg [31:0] dat_i=0,q;
  reg [15:0] st=0,ps=0;
  wire [15:0] sd;
  wire [31:0] dat_o;
  wire [1:0] fc;
  wire ack_o,fp,ck,lr,fr,mt,sa,eo;
  integer mismatches=0,tests_run=0,seed=32'h57c7c04a,m,i,n;
  always #10 clk_i=~clk_i;
  prsc_net_src NET(.clk_i(clk_i),.en_i(en),.fp_o(fp),.ck_o(ck));
  prsc_top #(.FP_TIMEOUT(20'd200)) DUT(.clk_i(clk_i),.rst_i(rst_i),.cyc_i(cyc_i),.stb_i(stb_i),.we_i(we_i),
    .adr_i(adr_i),.sel_i(4'hf),.dat_i(dat_i),.dat_o(dat_o),.ack_o(ack_o),.err_o(eo),.ref_pin_i(ref_pin_i),
    .frame_pulse_in_i(fp),.serial_clock_in_i(ck),.serial_stream_inputs_i(st),.loop_ref_o(lr),
    .ref_freq_code_o(fc),.free_run_o(fr),.master_track_o(mt),.stream_accept_o(sa),.stream_data_o(sd));
  task chk(input [31:0] g,e);
    begin
      tests_run=tests_run+1;
      if(g!==e) begin
        mismatches=mismatches+1;
        $display("mismatch %0t %h %h",$time,g,e);
      end
    end
  endtask
  task bus(input w,input [3:0] a,input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i<=1;stb_i<=1;we_i<=w;adr_i<=a;dat_i<=d;
      @(posedge clk_i);
      while(ack_o!==1'b1) @(posedge clk_i);
      q=dat_o;
      cyc_i<=0;stb_i<=0;
      repeat(2) @(posedge clk_i);
    end
  endtask
  task results;
    begin
      $display("tests_run %0d mismatches %0d",tests_run,mismatches);
      if(mismatches==0&&tests_run>0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat(20000) @(posedge clk_i);
    mismatches=mismatches+1;
    results;
  end
  initial begin
    repeat(16) @(posedge clk_i);
    rst_i<=0;
    bus(0,0,0); chk(q,0);
    for(i=0;i<8;i=i+1) begin
      m=i%2?2:i/2*8;
      bus(1,0,m|'hff64);
      bus(0,0,0); chk(q,m);
      chk(fc,i%2?0:i/2);
    end
    bus(1,0,0);
    for(i=0;i<16;i=i+1) begin
      if(i==8) bus(1,0,2);
      ref_pin_i<=$random(seed);
      repeat(3) @(posedge clk_i);
      chk(lr,i<8?ref_pin_i:0);
    end
    en<=1;
    repeat(300) @(posedge clk_i);
    n=0;
    for(i=0;i<400;i=i+1) begin
      @(posedge clk_i);
      chk(sd,ps);
      ps=st;
      st<=$random(seed);
      n=n+lr;
    end
    chk(n,10);
    chk(sa,1);
    en<=0;
    repeat(300) @(posedge clk_i);
    chk(sa,0);
    bus(0,4,0); chk(q,1);
    en<=1;
    repeat(300) @(posedge clk_i);
    chk(sa,1);
    bus(1,4,1); ref_pin_i<=0;
    bus(1,0,0); bus(0,4,0); chk(q,'h2c);
    bus(1,0,1); chk(fr,1); chk(mt,0);
    bus(1,8,'h4000); chk(fr,0); chk(mt,1);
    bus(0,'hc,0); chk(q,0); chk(eo,0);
    rst_i<=1; repeat(2) @(posedge clk_i);
    chk(mt,0); chk(fr,0); rst_i<=0;
    bus(0,8,0); chk(q,0); chk(mt,1);
    results;
  end
endmodule // prsc_top_tb
